/* File: common/fifo_flags_params.svh */
// Constants for the FIFO flag and clear-time configuration block.
// Assumes a single 10 MHz system clock that samples every pin.
`ifndef FIFO_FLAGS_PARAMS_SVH
`define FIFO_FLAGS_PARAMS_SVH

`define CLK_PERIOD_NS 100
`define DATA_W 36
`define DEPTH 1024
`define ADDR_W 10
`define PTR_W 11
`define OFS_W 10
`define UNIT_W 13
`define PIN_W 57
// Idle pin levels: clocks low, active-low strobes and clears high
`define PIN_IDLE {2'b00, 5'h1F, 9'h000, 2'b11, 1'b0, 1'b1, 1'b0, 36'h0}

// Register port map (word index)
`define REG_STATUS 2'h0
`define REG_CONTROL 2'h1
`define REG_OFFSETS 2'h2

// Status register fields
`define ST_FULL 0
`define ST_EMPTY 1
`define ST_AFULL 2
`define ST_AEMPTY 3
`define ST_CFG_LSB 8

// Default offsets chosen by strobe and the two select pins
`define DEF_OFS_0 10'h007
`define DEF_OFS_1 10'h01F
`define DEF_OFS_2 10'h03F
`define DEF_OFS_3 10'h07F
`define DEF_OFS_4 10'h0FF
`define DEF_OFS_5 10'h1FF
`define DEF_OFS_6 10'h00F
`define DEF_OFS_7 10'h003

// Configuration after reset: serial, big-endian, async, x36, std
`define CFG_RESET 29'h0800_1C07

`endif

/* File: common/fifo_flags_pkg.sv */
// Types shared by the flag block and its configuration capture.
// Assumes nothing beyond the constants header.
package fifo_flags_pkg;

  typedef enum logic [1:0] {
    PROG_EMPTY = 2'b01,
    PROG_FULL = 2'b10
  } prog_state_t;

  typedef struct packed {
    logic parallel_prog;
    logic big_endian;
    logic sync_flags;
    logic interspersed;
    logic fall_through_mode;
    logic [1:0] in_shift;
    logic [1:0] out_shift;
    logic [9:0] default_empty;
    logic [9:0] default_full;
  } cfg_t;

endpackage : fifo_flags_pkg

/* File: common/cfg_link_if.sv */
// Carries the latched clear-time configuration between modules.
// Assumes both ends run on the system clock.
interface cfg_link_if;
  import fifo_flags_pkg::*;
  cfg_t cfg;
  modport source (output cfg);
  modport sink (input cfg);
endinterface : cfg_link_if

/* File: src/cfg_capture.sv */
// Latches the configuration pins while a full clear is held.
// Assumes the pins are already synchronised to the system clock.
`include "fifo_flags_params.svh"
module cfg_capture (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic [9:0] cfg_pins_i,
  cfg_link_if.source link
);
  import fifo_flags_pkg::*;

  function automatic logic [9:0] default_offset(input logic [2:0] idx);
    case (idx)
      3'h0: default_offset = `DEF_OFS_0;
      3'h1: default_offset = `DEF_OFS_1;
      3'h2: default_offset = `DEF_OFS_2;
      3'h3: default_offset = `DEF_OFS_3;
      3'h4: default_offset = `DEF_OFS_4;
      3'h5: default_offset = `DEF_OFS_5;
      3'h6: default_offset = `DEF_OFS_6;
      default: default_offset = `DEF_OFS_7;
    endcase
  endfunction : default_offset

  // Pin order: strobe, sel0, sel1, match, in, out, order, timing, parity, ft
  wire strobe = cfg_pins_i[9];
  wire [2:0] ofs_idx = {strobe, cfg_pins_i[7], cfg_pins_i[8]};
  wire match = cfg_pins_i[6];
  wire iw = cfg_pins_i[5];
  wire ow = cfg_pins_i[4];
  wire [1:0] in_sh = (match & iw) ? (ow ? 2'h2 : 2'h1) : 2'h0;
  wire [1:0] out_sh = (match & ~iw) ? (ow ? 2'h2 : 2'h1) : 2'h0;
  cfg_t next_cfg;

  always_comb begin
    next_cfg.parallel_prog = ~strobe;
    next_cfg.big_endian = ~cfg_pins_i[3];
    next_cfg.sync_flags = cfg_pins_i[2];
    next_cfg.interspersed = cfg_pins_i[1];
    next_cfg.fall_through_mode = cfg_pins_i[0];
    next_cfg.in_shift = in_sh;
    next_cfg.out_shift = out_sh;
    next_cfg.default_empty = default_offset(ofs_idx);
    next_cfg.default_full = default_offset(ofs_idx);
  end

  // Held between clears, so a partial clear never touches it
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      link.cfg <= `CFG_RESET;
    end else if (ce_i && clear_i) begin
      link.cfg <= next_cfg;
    end
  end

  chk_cfg_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !clear_i |=> $stable(link.cfg)) else $error("config moved");
  chk_byte_order: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ce_i && clear_i |=> link.cfg.big_endian == !$past(cfg_pins_i[3]))
    else $error("byte order not latched");

endmodule : cfg_capture

/* File: src/fifo_flags_top.sv */
// FIFO status flags, offsets and clear-time configuration.
// Assumes all pins, the two port clocks included, are slower than the
// system clock; each is sampled through two flip-flops first.
//
// Our own choices: the placing of the registers and the strobed register port.
`include "fifo_flags_params.svh"
module fifo_flags_top (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic wclk_i,
  input wire logic rclk_i,
  input wire logic write_en_n_i,
  input wire logic read_en_n_i,
  input wire logic [35:0] data_i,
  input wire logic full_clear_n_i,
  input wire logic partial_clear_n_i,
  input wire logic offset_access_strobe_n_i,
  input wire logic default_offset_sel0_i,
  input wire logic default_offset_sel1_i,
  input wire logic width_match_select_i,
  input wire logic input_width_select_i,
  input wire logic output_width_select_i,
  input wire logic byte_order_select_i,
  input wire logic flag_timing_select_i,
  input wire logic parity_placement_select_i,
  input wire logic fall_through_mode_i,
  input wire logic mark_n_i,
  input wire logic retransmit_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_en_n_i,
  input wire logic serial_in_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [31:0] reg_rdata_o,
  output logic [35:0] data_o,
  output logic full_flag_o,
  output logic empty_flag_o,
  output logic almost_full_flag_o,
  output logic almost_empty_flag_o
);
  import fifo_flags_pkg::*;

  function automatic logic [35:0] place_part(input logic [35:0] word,
      input logic [35:0] part, input logic [1:0] idx,
      input logic [1:0] sh, input logic big);
    logic [35:0] w;
    logic [1:0] pos;
    w = word;
    pos = big ? ((2'h1 << sh) - 2'h1 - idx) : idx;
    case (sh)
      2'h1: w[pos[0]*18 +: 18] = part[17:0];
      2'h2: w[pos*9 +: 9] = part[8:0];
      default: w = part;
    endcase
    place_part = w;
  endfunction : place_part

  function automatic logic [35:0] pick_part(input logic [35:0] word,
      input logic [1:0] idx, input logic [1:0] sh, input logic big);
    logic [1:0] pos;
    pos = big ? ((2'h1 << sh) - 2'h1 - idx) : idx;
    case (sh)
      2'h1: pick_part = {18'h0, word[pos[0]*18 +: 18]};
      2'h2: pick_part = {27'h0, word[pos*9 +: 9]};
      default: pick_part = word;
    endcase
  endfunction : pick_part

  // Count in port units: long words times parts per word
  function automatic logic [12:0] units(input logic [10:0] cnt,
      input logic [1:0] sh);
    units = {2'h0, cnt} << sh;
  endfunction : units

  function automatic logic [9:0] parallel_offset(input logic [35:0] d,
      input logic inter);
    parallel_offset = inter ? {d[10:9], d[7:0]} : d[9:0];
  endfunction : parallel_offset

  // Two-stage sampling of every pin; clock pins get a third for edges
  logic [56:0] pin_s1, pin_s2;
  logic wclk_d, rclk_d, sclk_d;
  wire [56:0] pins_raw = {wclk_i, rclk_i, write_en_n_i, read_en_n_i,
    full_clear_n_i, partial_clear_n_i, offset_access_strobe_n_i,
    default_offset_sel0_i, default_offset_sel1_i, width_match_select_i,
    input_width_select_i, output_width_select_i, byte_order_select_i,
    flag_timing_select_i, parity_placement_select_i, fall_through_mode_i,
    mark_n_i, retransmit_n_i, serial_clk_i, serial_en_n_i, serial_in_i,
    data_i};
  wire s_wclk = pin_s2[56];
  wire s_rclk = pin_s2[55];
  wire s_wen_n = pin_s2[54];
  wire s_ren_n = pin_s2[53];
  wire s_fclr_n = pin_s2[52];
  wire s_pclr_n = pin_s2[51];
  wire s_ld_n = pin_s2[50];
  wire [9:0] s_cfg_pins = pin_s2[50:41];
  wire s_mark_n = pin_s2[40];
  wire s_rt_n = pin_s2[39];
  wire s_sclk = pin_s2[38];
  wire s_sen_n = pin_s2[37];
  wire s_si = pin_s2[36];
  wire [35:0] s_data = pin_s2[35:0];

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      // Zeros would look like a held full clear right after reset
      pin_s1 <= `PIN_IDLE;
      pin_s2 <= `PIN_IDLE;
      wclk_d <= 1'b0;
      rclk_d <= 1'b0;
      sclk_d <= 1'b0;
    end else if (ce_i) begin
      pin_s1 <= pins_raw;
      pin_s2 <= pin_s1;
      wclk_d <= s_wclk;
      rclk_d <= s_rclk;
      sclk_d <= s_sclk;
    end
  end

  cfg_link_if cfg_link ();
  cfg_t cfg;
  assign cfg = cfg_link.cfg;
  wire full_clr = ~s_fclr_n;
  logic soft_clear;
  wire clr = full_clr | ~s_pclr_n | soft_clear;

  cfg_capture u_cfg (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .clear_i(full_clr),
    .cfg_pins_i(s_cfg_pins),
    .link(cfg_link.source)
  );

  wire wr_edge = ce_i & s_wclk & ~wclk_d & ~clr;
  wire rd_edge = ce_i & s_rclk & ~rclk_d & ~clr;
  wire sclk_edge = ce_i & s_sclk & ~sclk_d & ~clr;

  logic [35:0] mem [0:`DEPTH-1];
  logic [10:0] wptr, rptr, cptr, mark_ptr;
  logic [10:0] base_w1, cons_w1, wptr_r1, wptr_r2;
  logic retrans_mode;
  logic [35:0] asm_word, out_word;
  logic [1:0] in_part, out_part;
  logic out_valid;
  logic [9:0] empty_ofs, full_ofs;
  prog_state_t wr_ofs_sel, rd_ofs_sel;

  // Write side; the strobe must be high for data
  wire data_wr = wr_edge & ~s_wen_n & s_ld_n;
  wire full_block = cfg.fall_through_mode ? full_flag_o : ~full_flag_o;
  wire wr_ok = data_wr & ~full_block;
  wire in_last = in_part == ((2'h1 << cfg.in_shift) - 2'h1);
  wire word_wr = wr_ok & in_last;
  wire [35:0] wr_word = place_part(asm_word, s_data, in_part,
    cfg.in_shift, cfg.big_endian);
  wire [10:0] next_wptr = wptr + {10'h0, word_wr};
  wire [10:0] mem_next_w = next_wptr - base_w1;
  wire [10:0] tot_next_w = next_wptr - cons_w1;
  wire full_hit = mem_next_w == 11'(`DEPTH);
  wire [12:0] af_thr = units(11'(`DEPTH) + {10'h0, cfg.fall_through_mode},
    cfg.in_shift) - {3'h0, full_ofs};
  wire af_hit_w = units(tot_next_w, cfg.in_shift) >= af_thr;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || (ce_i && clr)) begin
      wptr <= '0;
      in_part <= '0;
      asm_word <= '0;
      base_w1 <= '0;
      cons_w1 <= '0;
      full_flag_o <= ~cfg.fall_through_mode;
    end else if (wr_edge) begin
      base_w1 <= retrans_mode ? mark_ptr : rptr;
      cons_w1 <= retrans_mode ? mark_ptr : cptr;
      full_flag_o <= cfg.fall_through_mode ? full_hit : ~full_hit;
      if (wr_ok) begin
        asm_word <= wr_word;
        in_part <= in_last ? 2'h0 : in_part + 2'h1;
        wptr <= next_wptr;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (word_wr) begin
      mem[wptr[9:0]] <= wr_word;
    end
  end

  // Read side
  wire rd_req = rd_edge & ~s_ren_n & s_ld_n;
  wire [1:0] out_max = (2'h1 << cfg.out_shift) - 2'h1;
  wire avail_std = wptr_r1 != rptr;
  wire avail_ft = wptr_r2 != rptr;
  wire [35:0] mem_word = mem[rptr[9:0]];
  wire std_ok = rd_req & ~cfg.fall_through_mode & empty_flag_o;
  wire std_load = std_ok & (out_part == 2'h0);
  wire ft_take = rd_req & cfg.fall_through_mode & out_valid;
  wire ft_done = ft_take & (out_part == out_max);
  wire ft_load = cfg.fall_through_mode & avail_ft & (ft_done | ~out_valid);
  wire load = std_load | ft_load;
  wire [1:0] next_part = (std_ok | ft_take)
    ? ((out_part == out_max) ? 2'h0 : out_part + 2'h1) : out_part;
  wire consumed = (std_ok | ft_take) & (out_part == out_max);
  wire [10:0] next_rptr = rptr + {10'h0, load};
  wire [10:0] next_cptr = cptr + {10'h0, consumed};
  wire next_valid = ft_load | (out_valid & ~ft_done);
  wire [35:0] shown = load ? mem_word : out_word;
  wire [1:0] shown_idx = std_ok ? out_part : next_part;
  // Fresh write count: a stopped read clock leaves the staged copy stale
  wire [10:0] tot_r = wptr - next_cptr;
  wire [12:0] ae_thr = {3'h0, empty_ofs} + {12'h0, cfg.fall_through_mode};
  wire ae_hit_r = units(tot_r, cfg.out_shift) <= ae_thr;
  wire af_hit_r = units(tot_r, cfg.in_shift) >= af_thr;
  wire ae_hit_w = units(tot_next_w, cfg.out_shift) <= ae_thr;

  // Offset access with the strobe low; reads only on the parallel port
  wire ofs_rd = rd_edge & ~s_ren_n & ~s_ld_n;
  wire ofs_wr = wr_edge & ~s_wen_n & ~s_ld_n & cfg.parallel_prog;
  wire ser_wr = sclk_edge & ~s_sen_n & ~s_ld_n & ~cfg.parallel_prog;
  wire [9:0] ofs_val = parallel_offset(s_data, cfg.interspersed);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || (ce_i && clr)) begin
      rptr <= '0;
      cptr <= '0;
      wptr_r1 <= '0;
      wptr_r2 <= '0;
      out_part <= '0;
      out_valid <= 1'b0;
      out_word <= '0;
      data_o <= '0;
      empty_flag_o <= cfg.fall_through_mode;
      rd_ofs_sel <= PROG_EMPTY;
    end else if (rd_edge) begin
      wptr_r1 <= wptr;
      wptr_r2 <= wptr_r1;
      rptr <= s_rt_n ? next_rptr : mark_ptr;
      cptr <= s_rt_n ? next_cptr : mark_ptr;
      out_part <= next_part;
      out_valid <= next_valid;
      if (load) begin
        out_word <= mem_word;
      end
      if (ofs_rd) begin
        data_o <= {26'h0, (rd_ofs_sel == PROG_EMPTY) ? empty_ofs : full_ofs};
        rd_ofs_sel <= (rd_ofs_sel == PROG_EMPTY) ? PROG_FULL : PROG_EMPTY;
      end else if (std_ok || load || ft_take) begin
        // Last word stays on the outputs once drained
        data_o <= pick_part(shown, shown_idx, cfg.out_shift,
          cfg.big_endian);
      end
      if (cfg.fall_through_mode) begin
        empty_flag_o <= ~next_valid;
      end else begin
        empty_flag_o <= (wptr_r1 != next_rptr) | (next_part != 2'h0);
      end
    end
  end

  // Marked location for retransmit
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || (ce_i && clr)) begin
      mark_ptr <= '0;
      retrans_mode <= 1'b0;
    end else if (rd_edge) begin
      retrans_mode <= ~s_mark_n;
      if (~s_mark_n && !retrans_mode) begin
        mark_ptr <= rptr;
      end
    end
  end

  // Almost flags: sync mode moves on own edge, async is split
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || (ce_i && clr)) begin
      almost_empty_flag_o <= 1'b0;
      almost_full_flag_o <= 1'b1;
    end else if (cfg.sync_flags) begin
      if (rd_edge) begin
        almost_empty_flag_o <= ~ae_hit_r;
      end
      if (wr_edge) begin
        almost_full_flag_o <= ~af_hit_w;
      end
    end else begin
      if (rd_edge && ae_hit_r) begin
        almost_empty_flag_o <= 1'b0;
      end else if (wr_edge && !ae_hit_w) begin
        almost_empty_flag_o <= 1'b1;
      end
      if (wr_edge && af_hit_w) begin
        almost_full_flag_o <= 1'b0;
      end else if (rd_edge && !af_hit_r) begin
        almost_full_flag_o <= 1'b1;
      end
    end
  end

  // Offsets survive a partial clear; full clear reloads defaults
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || (ce_i && full_clr)) begin
      empty_ofs <= cfg.default_empty;
      full_ofs <= cfg.default_full;
      wr_ofs_sel <= PROG_EMPTY;
    end else if (ce_i && reg_write_i && reg_addr_i == `REG_OFFSETS) begin
      empty_ofs <= reg_wdata_i[9:0];
      full_ofs <= reg_wdata_i[25:16];
    end else if (ofs_wr) begin
      case (wr_ofs_sel)
        PROG_EMPTY: begin
          empty_ofs <= ofs_val;
          wr_ofs_sel <= PROG_FULL;
        end
        PROG_FULL: begin
          full_ofs <= ofs_val;
          wr_ofs_sel <= PROG_EMPTY;
        end
        default: wr_ofs_sel <= PROG_EMPTY;
      endcase
    end else if (ser_wr) begin
      {full_ofs, empty_ofs} <= {full_ofs[8:0], empty_ofs, s_si};
    end
  end

  // Register port: read data one cycle after the strobe
  wire [31:0] status_word = {19'h0, cfg.fall_through_mode, cfg.interspersed,
    cfg.sync_flags, cfg.big_endian, cfg.parallel_prog, cfg.out_shift,
    cfg.in_shift, almost_empty_flag_o, almost_full_flag_o, empty_flag_o,
    full_flag_o};
  wire [31:0] rd_mux = (reg_addr_i == `REG_STATUS) ? status_word :
    (reg_addr_i == `REG_OFFSETS) ? {6'h0, full_ofs, 6'h0, empty_ofs} :
    32'h0000_0000;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
      soft_clear <= 1'b0;
    end else if (ce_i) begin
      reg_rdata_o <= reg_read_i ? rd_mux : 32'h0000_0000;
      // Software clear behaves like a one-cycle partial clear
      soft_clear <= reg_write_i && reg_addr_i == `REG_CONTROL
        && reg_wdata_i[0];
    end
  end

  chk_full_block: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !cfg.fall_through_mode && !full_flag_o && wr_edge |=> $stable(wptr))
    else $error("write taken while full");
  chk_full_depth: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !clr && !cfg.fall_through_mode && !full_flag_o |-> wptr - base_w1 == 11'(`DEPTH))
    else $error("full flag without full memory");
  chk_ready_depth: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !clr && cfg.fall_through_mode && full_flag_o |-> wptr - base_w1 == 11'(`DEPTH))
    else $error("input ready high without full memory");
  chk_empty_ignore: assert property (@(posedge sys_clk_i)
    disable iff (reset_i)
    !cfg.fall_through_mode && !empty_flag_o && rd_edge && s_rt_n |=> $stable(rptr))
    else $error("read taken while empty");
  chk_ready_rise: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cfg.fall_through_mode && !clr && !$past(clr) && $rose(empty_flag_o)
    |-> $past(rd_req))
    else $error("output ready released without read");
  chk_ae_sync: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cfg.sync_flags && !$past(rd_edge) && !$past(clr)
    |-> $stable(almost_empty_flag_o))
    else $error("almost-empty moved off read edge");
  chk_af_sync: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cfg.sync_flags && !$past(wr_edge) && !$past(clr)
    |-> $stable(almost_full_flag_o))
    else $error("almost-full moved off write edge");
  chk_ae_release: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !cfg.sync_flags && !$past(clr) && $rose(almost_empty_flag_o)
    |-> $past(wr_edge))
    else $error("almost-empty released off write edge");

endmodule : fifo_flags_top

/* File: testbench/fifo_port_model.sv */
// Writer and reader logic facing the FIFO port pins.
// Assumes a free system clock; port clocks stand still between pulses.
module fifo_port_model (
  input wire logic sys_clk_i,
  output logic wclk_o,
  output logic rclk_o,
  output logic write_en_n_o,
  output logic read_en_n_o,
  output logic [35:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {wclk_o, rclk_o, write_en_n_o, read_en_n_o} = 4'b0011;
    data_o = 36'h0;
  end
  // One port clock pulse; a larger hold acts as a slow partner
  task automatic pulse(input logic wr, input logic en,
      input logic [35:0] d, input int hold);
    @(posedge sys_clk_i);
    if (wr) begin
      write_en_n_o <= !en;
      data_o <= d;
    end else begin
      read_en_n_o <= !en;
    end
    @(posedge sys_clk_i);
    wclk_o <= wr;
    rclk_o <= !wr;
    repeat (hold) @(posedge sys_clk_i);
    {wclk_o, rclk_o} <= 2'b00;
    repeat (hold) @(posedge sys_clk_i);
    {write_en_n_o, read_en_n_o} <= 2'b11;
    // Released bus must never look like the word just written
    if (wr) begin
      data_o <= ~d;
    end
  endtask : pulse
endmodule : fifo_port_model

/* File: testbench/fifo_flags_and_reset_config_test.sv */
// Self-checking bench for the FIFO flag and clear-time config block.
// Assumes the port model drives the write and read port pins.
module fifo_flags_and_reset_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i, reset_i, ce_i, wclk_i, rclk_i, write_en_n_i, read_en_n_i;
  logic [35:0] data_i, data_o, word;
  logic full_clear_n_i, partial_clear_n_i, offset_access_strobe_n_i;
  logic default_offset_sel0_i, default_offset_sel1_i, width_match_select_i;
  logic input_width_select_i, output_width_select_i, byte_order_select_i;
  logic flag_timing_select_i, parity_placement_select_i, fall_through_mode_i;
  logic mark_n_i, retransmit_n_i, serial_clk_i, serial_en_n_i, serial_in_i;
  logic [1:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, st;
  logic reg_write_i, reg_read_i, full_flag_o, empty_flag_o;
  logic almost_full_flag_o, almost_empty_flag_o;
  logic [8:0] pins;
  int num_errors = 0;
  int check_count = 0;
  assign {default_offset_sel1_i, default_offset_sel0_i, width_match_select_i,
    input_width_select_i, output_width_select_i, byte_order_select_i,
    flag_timing_select_i, parity_placement_select_i,
    fall_through_mode_i} = pins;
  fifo_flags_top dut (.*);
  fifo_port_model port (.sys_clk_i(sys_clk_i), .wclk_o(wclk_i),
    .rclk_o(rclk_i), .write_en_n_o(write_en_n_i),
    .read_en_n_o(read_en_n_i), .data_o(data_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [35:0] got, input logic [35:0] exp,
      input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chkf(input logic got, input logic exp, input string what);
    chk({35'h0, got}, {35'h0, exp}, what);
  endtask : chkf
  task automatic rd(input logic [1:0] a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_read_i <= 1'b0;
    #1 st = reg_rdata_o;
  endtask : rd
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    {reg_addr_i, reg_wdata_i, reg_write_i} <= {a, d, 1'b1};
    @(posedge sys_clk_i);
    reg_write_i <= 1'b0;
  endtask : wr
  task automatic w(input logic [35:0] d);
    port.pulse(1'b1, 1'b1, d, 4);
  endtask : w
  task automatic rp(input logic en);
    port.pulse(1'b0, en, 36'h0, 4);
  endtask : rp
  task automatic strobe(input logic v);
    @(posedge sys_clk_i);
    offset_access_strobe_n_i <= v;
  endtask : strobe
  // p = {strobe_n, sel1, sel0, bm, iw, ow, be, pfm, ip, fall_through_mode}
  task automatic clear(input logic [9:0] p);
    strobe(p[9]);
    pins <= p[8:0];
    full_clear_n_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    full_clear_n_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    strobe(1'b1);
  endtask : clear
  task automatic t_config();
    clear(10'b11_1000_0000);
    rd(2'h0);
    chk({4'h0, st}, 36'h205, "status A");
    rd(2'h2);
    chk({4'h0, st}, 36'h0003_0003, "default ofs");
    wr(2'h0, 32'hFFFF_FFFF);
    rd(2'h3);
    chk({4'h0, st}, 36'h0, "unmapped");
    clear(10'b00_0000_1111);
    rd(2'h0);
    chk({27'h0, st[12:4]}, 36'h1D0, "status B");
    rd(2'h2);
    chk({4'h0, st}, 36'h0007_0007, "default ofs B");
  endtask : t_config
  task automatic t_prog_inter();
    strobe(1'b0);
    w(36'h8_0402_05A5);
    w(36'h8_0402_035A);
    strobe(1'b1);
    rd(2'h2);
    chk({4'h0, st}, 36'h015A_02A5, "inter ofs");
  endtask : t_prog_inter
  task automatic t_retain();
    @(posedge sys_clk_i);
    pins <= ~pins;
    ce_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    {ce_i, partial_clear_n_i} <= 2'b10;
    repeat (4) @(posedge sys_clk_i);
    partial_clear_n_i <= 1'b1;
    wr(2'h1, 32'h1);
    rd(2'h0);
    chk({27'h0, st[12:4]}, 36'h1D0, "kept cfg");
    rd(2'h2);
    chk({4'h0, st}, 36'h015A_02A5, "kept ofs");
  endtask : t_retain
  task automatic t_fall_through_mode();
    w(36'h5_A5A5_1234);
    rp(1'b0);
    rp(1'b0);
    chkf(empty_flag_o, 1'b1, "early ready");
    rp(1'b0);
    chkf(empty_flag_o, 1'b0, "ready");
    chk(data_o, 36'h5_A5A5_1234, "fall data");
    chkf(full_flag_o, 1'b0, "space");
    rp(1'b1);
    chkf(empty_flag_o, 1'b1, "drained");
    chk(data_o, 36'h5_A5A5_1234, "held");
  endtask : t_fall_through_mode
  task automatic t_fill();
    int c;
    clear(10'b00_0000_0000);
    strobe(1'b0);
    w(36'hF_0000_0104);
    w(36'hF_0000_0105);
    strobe(1'b1);
    rd(2'h2);
    chk({4'h0, st}, 36'h0105_0104, "plain ofs");
    // Last pass is refused: the memory is already full
    for (int k = 1; k <= 1025; k++) begin
      w(36'hA_0000_0000 + 36'(k));
      chkf(full_flag_o, k < 1024, "full");
      chkf(almost_full_flag_o, k < 763, "afull");
      chkf(almost_empty_flag_o, k > 260, "aempty");
    end
    repeat (3) rp(1'b0);
    chkf(empty_flag_o, 1'b1, "not empty");
    for (int k = 1; k <= 1025; k++) begin
      rp(1'b1);
      c = (k > 1024) ? 0 : 1024 - k;
      chk(data_o, 36'hA_0000_0000 + 36'(k > 1024 ? 1024 : k), "rd");
      chkf(empty_flag_o, c != 0, "empty");
      chkf(almost_full_flag_o, c < 763, "afull rd");
      chkf(almost_empty_flag_o, c > 260, "aempty rd");
    end
  endtask : t_fill
  task automatic t_width();
    for (int b = 0; b < 2; b++) begin
      clear({6'b11_1100, 1'(b), 3'b000});
      word = 36'h9_8765_4321;
      w(word);
      repeat (3) rp(1'b0);
      rp(1'b1);
      chk(data_o, {18'h0, b ? word[17:0] : word[35:18]}, "1st");
      rp(1'b1);
      chk(data_o, {18'h0, b ? word[35:18] : word[17:0]}, "2nd");
    end
  endtask : t_width
  task automatic report_and_stop();
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #5_000_000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {reset_i, ce_i, full_clear_n_i, partial_clear_n_i} = 4'b1111;
    {mark_n_i, retransmit_n_i, serial_en_n_i} = 3'b111;
    {serial_clk_i, serial_in_i, reg_write_i, reg_read_i} = 4'b0;
    {reg_addr_i, reg_wdata_i} = 34'h0;
    {offset_access_strobe_n_i, pins} = 10'h200;
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_config();
    t_prog_inter();
    t_retain();
    t_fall_through_mode();
    t_fill();
    t_width();
    report_and_stop();
  end
endmodule : fifo_flags_and_reset_config_test
